// [logic/tsw_pin_sync.sv]
// Shared constants for the threshold serial and wake block, plus the pin
// synchroniser with edge detection used on every asynchronous input.
// Assumes pins arrive from outside the sys_clk domain and may float low.
`default_nettype none

package tsw_pkg;
  // Mode-select decode, code is {mode_sel1, mode_sel0}
  typedef enum logic [1:0] {
    TSW_STANDBY  = 2'b00,
    TSW_PRESSURE = 2'b01,
    TSW_TEMP     = 2'b10,
    TSW_READ     = 2'b11
  } tsw_mode_t;

  // Divider chain lengths in oscillator cycles
  localparam int unsigned TSW_WAKE_DIV = 16384;
  localparam int unsigned TSW_RESET_DIV = 16777216;
  localparam int TSW_WAKE_BITS = 14;
  localparam int TSW_RESET_BITS = 24;
  // Nominal reset pulse period in minutes
  localparam int unsigned TSW_RESET_PERIOD_MIN = 52;
  // Low time of both pulses, in oscillator cycles
  localparam logic [23:0] TSW_PULSE_LEN = 24'h000002;
  // Divider start value keeps the outputs quiet after reset
  localparam logic [23:0] TSW_DIV_START = 24'h000002;

  // Serial receiver
  localparam int TSW_DATA_BITS = 8;
  localparam logic [3:0] TSW_LAST_BIT = 4'h7;
  localparam logic [3:0] TSW_CNT_ZERO = 4'h0;
  localparam logic [7:0] TSW_DAC_RESET = 8'h00;

  // Synchronised pin positions
  localparam int TSW_PIN_OSC = 0;
  localparam int TSW_PIN_SCLK = 1;
  localparam int TSW_PIN_DATA = 2;
  localparam int TSW_PIN_SEL0 = 3;
  localparam int TSW_PIN_SEL1 = 4;
  localparam int TSW_PIN_COMP = 5;
  localparam int TSW_PINS = 6;
endpackage

// Two-flop synchroniser per pin, a third flop for edge detection
module tsw_pin_sync #(
  parameter int N = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [N-1:0] pin_raw,
  output logic [N-1:0] pin_level,
  output logic [N-1:0] pin_rise,
  output logic [N-1:0] pin_fall
);
  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] level;
    logic [N-1:0] prev;
  } tsw_sync_t;

  tsw_sync_t st;
  tsw_sync_t next_st;

  // Shift each pin through the stages; meta feeds only level
  always_comb begin
    next_st.meta = pin_raw;
    next_st.level = st.meta;
    next_st.prev = st.level;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Edge flags come from the settled stages only
  for (genvar i = 0; i < N; i++) begin : g_edge
    assign pin_level[i] = st.level[i];
    assign pin_rise[i] = st.level[i] & ~st.prev[i];
    assign pin_fall[i] = ~st.level[i] & st.prev[i];
  end
endmodule

`default_nettype wire

// [logic/tsw_threshold_wake.sv]
// Threshold serial loader, mode decode and oscillator divider chain.
// Assumes all pins are asynchronous to sys_clk and low when undriven;
// the oscillator pin is slow enough to be sampled by sys_clk.
`default_nettype none

module tsw_threshold_wake #(
  parameter int unsigned RESET_DIV = tsw_pkg::TSW_RESET_DIV,
  parameter int unsigned WAKE_DIV = tsw_pkg::TSW_WAKE_DIV
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic low_freq_osc,
  input wire logic mode_sel0,
  input wire logic mode_sel1,
  input wire logic serial_in_line,
  input wire logic serial_clk_line,
  input wire logic comparator_above,
  output logic wake_output,
  output logic mcu_reset_pulse_n,
  output logic [7:0] threshold_dac_register,
  output logic pressure_meas_en,
  output logic temp_current_en,
  output logic readout_comp_en,
  output logic [1:0] active_mode
);
  typedef struct packed {
    logic [23:0] div;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] dac;
    tsw_pkg::tsw_mode_t mode;
    logic wake;
    logic reset_n;
    logic press_en;
    logic temp_en;
    logic comp_en;
    logic [2:0] low_ticks;
  } tsw_state_t;

  tsw_state_t st;
  tsw_state_t next_st;

  logic [tsw_pkg::TSW_PINS-1:0] pin_raw;
  logic [tsw_pkg::TSW_PINS-1:0] pin_level;
  logic [tsw_pkg::TSW_PINS-1:0] pin_rise;
  logic [tsw_pkg::TSW_PINS-1:0] pin_fall;
  logic osc_tick;
  logic sclk_rise;
  logic sclk_fall;
  logic data_level;
  logic comp_level;
  tsw_pkg::tsw_mode_t pin_mode;
  logic measuring;
  logic [23:0] div_mask;
  logic [23:0] wake_mask;
  logic [23:0] div_step;

  // Gather pins; undriven pins are pulled low by the pad cells
  assign pin_raw[tsw_pkg::TSW_PIN_OSC] = low_freq_osc;
  assign pin_raw[tsw_pkg::TSW_PIN_SCLK] = serial_clk_line;
  assign pin_raw[tsw_pkg::TSW_PIN_DATA] = serial_in_line;
  assign pin_raw[tsw_pkg::TSW_PIN_SEL0] = mode_sel0;
  assign pin_raw[tsw_pkg::TSW_PIN_SEL1] = mode_sel1;
  assign pin_raw[tsw_pkg::TSW_PIN_COMP] = comparator_above;

  tsw_pin_sync #(
    .N(tsw_pkg::TSW_PINS)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_raw(pin_raw),
    .pin_level(pin_level),
    .pin_rise(pin_rise),
    .pin_fall(pin_fall)
  );

  // Settled pin views
  assign osc_tick = pin_rise[tsw_pkg::TSW_PIN_OSC];
  assign sclk_rise = pin_rise[tsw_pkg::TSW_PIN_SCLK];
  assign sclk_fall = pin_fall[tsw_pkg::TSW_PIN_SCLK];
  assign data_level = pin_level[tsw_pkg::TSW_PIN_DATA];
  assign comp_level = pin_level[tsw_pkg::TSW_PIN_COMP];

  // Mode decode straight from the two select pins
  assign pin_mode = tsw_pkg::tsw_mode_t'({pin_level[tsw_pkg::TSW_PIN_SEL1],
                                          pin_level[tsw_pkg::TSW_PIN_SEL0]});
  assign measuring = (pin_mode == tsw_pkg::TSW_PRESSURE) ||
                     (pin_mode == tsw_pkg::TSW_TEMP);

  // Divider wrap masks; a shortened chain for simulation uses the same logic
  assign div_mask = 24'(RESET_DIV - 1);
  assign wake_mask = 24'(WAKE_DIV - 1);
  assign div_step = (st.div + 24'h000001) & div_mask;

  always_comb begin
    next_st = st;

    // Divider chain counts oscillator cycles in every mode
    if (osc_tick) begin
      next_st.div = div_step;
    end

    // Reset output low for the first two counts after full overflow
    next_st.reset_n = !(next_st.div < tsw_pkg::TSW_PULSE_LEN);

    // Oscillator edges seen while the reset output is low, for the checks
    if (st.reset_n) begin
      next_st.low_ticks = 3'h0;
    end else if (osc_tick) begin
      next_st.low_ticks = st.low_ticks + 3'h1;
    end

    // Mode and analog enables follow the pins
    next_st.mode = pin_mode;
    next_st.press_en = 1'b0;
    next_st.temp_en = 1'b0;
    next_st.comp_en = 1'b0;
    case (pin_mode)
      tsw_pkg::TSW_STANDBY: begin
        next_st.wake = !((next_st.div & wake_mask) < tsw_pkg::TSW_PULSE_LEN);
      end
      tsw_pkg::TSW_PRESSURE: begin
        next_st.press_en = 1'b1;
        next_st.wake = comp_level;
      end
      tsw_pkg::TSW_TEMP: begin
        next_st.temp_en = 1'b1;
        next_st.wake = comp_level;
      end
      tsw_pkg::TSW_READ: begin
        next_st.comp_en = 1'b1;
        next_st.wake = comp_level;
      end
      default: begin
        next_st.wake = 1'b1;
      end
    endcase

    // Shared divider: the reset pulse always shows on wake as well
    if (!next_st.reset_n) begin
      next_st.wake = 1'b0;
    end

    // Serial receiver; measure modes hold the counter at zero
    if (measuring) begin
      next_st.bit_cnt = tsw_pkg::TSW_CNT_ZERO;
    end else begin
      if (sclk_rise) begin
        next_st.shift = {st.shift[6:0], data_level};
      end
      if (sclk_fall) begin
        if (st.bit_cnt == tsw_pkg::TSW_LAST_BIT) begin
          next_st.dac = st.shift;
          next_st.bit_cnt = tsw_pkg::TSW_CNT_ZERO;
        end else begin
          next_st.bit_cnt = st.bit_cnt + 4'h1;
        end
      end
    end
  end

  // State register; threshold is only touched by a completed byte
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st.div <= tsw_pkg::TSW_DIV_START;
      st.shift <= tsw_pkg::TSW_DAC_RESET;
      st.bit_cnt <= tsw_pkg::TSW_CNT_ZERO;
      st.dac <= tsw_pkg::TSW_DAC_RESET;
      st.mode <= tsw_pkg::TSW_STANDBY;
      st.wake <= 1'b1;
      st.reset_n <= 1'b1;
      st.press_en <= 1'b0;
      st.temp_en <= 1'b0;
      st.comp_en <= 1'b0;
      st.low_ticks <= 3'h0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wake_output = st.wake;
  assign mcu_reset_pulse_n = st.reset_n;
  assign threshold_dac_register = st.dac;
  assign pressure_meas_en = st.press_en;
  assign temp_current_en = st.temp_en;
  assign readout_comp_en = st.comp_en;
  assign active_mode = st.mode;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Reset pulse starts only at full overflow
  rst_fall_cause_a : assert property (
    $fell(mcu_reset_pulse_n) |-> (st.div == 24'h000000) && $past(osc_tick))
    else $error("reset pulse without divider overflow");

  // Overflow always produces the pulse, whatever the mode
  rst_every_wrap_a : assert property (
    (st.div == 24'h000000) && $changed(st.div) |-> !mcu_reset_pulse_n)
    else $error("divider overflow without reset pulse");

  // Low time is two oscillator periods
  rst_low_len_a : assert property (
    !mcu_reset_pulse_n |-> st.low_ticks < 3'h2)
    else $error("reset pulse longer than two periods");

  rst_release_a : assert property (
    $rose(mcu_reset_pulse_n) |-> $past(st.low_ticks) == 3'h1 && $past(osc_tick))
    else $error("reset pulse released at wrong time");

  // Wake follows reset pulse
  wake_with_rst_a : assert property (
    !mcu_reset_pulse_n |-> !wake_output)
    else $error("wake not pulsed with reset");

  // Standby idles wake high away from overflow
  standby_wake_a : assert property (
    (st.mode == tsw_pkg::TSW_STANDBY) && ((st.div & wake_mask) >= tsw_pkg::TSW_PULSE_LEN)
    |-> wake_output)
    else $error("standby wake low away from overflow");

  // Outside standby wake shows the comparator
  read_wake_a : assert property (
    (pin_mode != tsw_pkg::TSW_STANDBY) && (next_st.div >= tsw_pkg::TSW_PULSE_LEN)
    |=> wake_output == $past(comp_level))
    else $error("wake does not follow comparator");

  // Rising serial clock shifts data in at the bottom
  shift_in_a : assert property (
    sclk_rise && !measuring |=> st.shift == {$past(st.shift[6:0]), $past(data_level)})
    else $error("serial bit not shifted in");

  // Eighth falling edge latches and rewinds the count
  byte_latch_a : assert property (
    sclk_fall && !measuring && (st.bit_cnt == tsw_pkg::TSW_LAST_BIT)
    |=> (threshold_dac_register == $past(st.shift)) && (st.bit_cnt == 4'h0))
    else $error("threshold not latched on eighth fall");

  // Threshold stays put without a completed byte
  dac_hold_a : assert property (
    !(sclk_fall && !measuring && (st.bit_cnt == tsw_pkg::TSW_LAST_BIT))
    |=> $stable(threshold_dac_register))
    else $error("threshold changed without a byte");

  // Measure modes clear the bit counter
  cnt_clear_a : assert property (
    measuring |=> st.bit_cnt == 4'h0)
    else $error("bit counter not cleared in measure");

  // Temperature current only in temperature mode
  temp_src_a : assert property (
    temp_current_en == (active_mode == tsw_pkg::TSW_TEMP))
    else $error("temperature current source misdriven");

  // Pressure and readout enables follow the decoded mode
  mode_enables_a : assert property (
    (pressure_meas_en == (active_mode == tsw_pkg::TSW_PRESSURE)) &&
    (readout_comp_en == (active_mode == tsw_pkg::TSW_READ)))
    else $error("mode enables misdecoded");

  // Standby wake drops for the first counts of each short wrap
  standby_pulse_a : assert property (
    (st.mode == tsw_pkg::TSW_STANDBY) && ((st.div & wake_mask) < tsw_pkg::TSW_PULSE_LEN)
    |-> !wake_output)
    else $error("standby wake missed divider overflow");

  // Bit counter never runs past the last bit of a byte
  cnt_range_a : assert property (
    st.bit_cnt <= tsw_pkg::TSW_LAST_BIT)
    else $error("bit counter out of range");

  // Earlier falling edges advance the bit counter by one
  cnt_step_a : assert property (
    sclk_fall && !measuring && (st.bit_cnt != tsw_pkg::TSW_LAST_BIT)
    |=> st.bit_cnt == $past(st.bit_cnt) + 4'h1)
    else $error("bit counter did not advance");

  // Measure modes leave the shift register untouched
  shift_hold_a : assert property (
    measuring |=> $stable(st.shift))
    else $error("shift register moved in measure mode");
endmodule

`default_nettype wire

// [verif/tsw_mcu_model.sv]
// External controller model: drives the threshold serial data and clock.
// Assumes the bench calls send_bits from its main sequence at sys_clk edges.
`default_nettype none
module tsw_mcu_model (
  input wire logic sys_clk,
  output var logic serial_in_line,
  output var logic serial_clk_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lines start idle low, as the pin pull-downs leave them
  initial begin
    serial_in_line = 1'b0;
    serial_clk_line = 1'b0;
  end

  // Sends the top n bits of b, MSB first, 12 cycles (48 ns) a bit
  task automatic send_bits(input logic [7:0] b, input int n);
    @(posedge sys_clk);
    for (int i = 7; i > 7 - n; i--) begin
      serial_clk_line <= 1'b0;
      repeat (3) @(posedge sys_clk);
      serial_in_line <= b[i];
      repeat (3) @(posedge sys_clk);
      serial_clk_line <= 1'b1;
      repeat (6) @(posedge sys_clk);
    end
    serial_clk_line <= 1'b0;
    repeat (3) @(posedge sys_clk);
    serial_in_line <= 1'b0; // Released line falls to its pull-down
  endtask
endmodule
`default_nettype wire

// [verif/tb_sensor_threshold_serial_and_wake.sv]
// Testbench: serial threshold loads, mode decode and divider pulse checks.
// Assumes shortened dividers (64 and 16) and an oscillator of 8 sys_clk cycles.
`default_nettype none
module tb_sensor_threshold_serial_and_wake;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RDIV = 64;
  localparam int WDIV = 16;
  // Run limit, about three times the expected length of the sequence
  localparam int TIMEOUT_CYC = 8000;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic low_freq_osc = 1'b0;
  logic mode_sel0 = 1'b0;
  logic mode_sel1 = 1'b0;
  logic comparator_above = 1'b0;
  logic serial_in_line;
  logic serial_clk_line;
  logic wake_output;
  logic mcu_reset_pulse_n;
  logic [7:0] threshold_dac_register;
  logic pressure_meas_en;
  logic temp_current_en;
  logic readout_comp_en;
  logic [1:0] active_mode;
  logic [7:0] exp_thr = 8'h00;
  logic wake_chk = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int ph = 0;
  int mdiv = 2;
  integer seed = 42597;
  logic [7:0] sample = 8'h00;
  logic [7:0] sar = 8'h00;

  tsw_threshold_wake #(.RESET_DIV(RDIV), .WAKE_DIV(WDIV)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .low_freq_osc(low_freq_osc),
    .mode_sel0(mode_sel0), .mode_sel1(mode_sel1), .serial_in_line(serial_in_line),
    .serial_clk_line(serial_clk_line), .comparator_above(comparator_above),
    .wake_output(wake_output), .mcu_reset_pulse_n(mcu_reset_pulse_n),
    .threshold_dac_register(threshold_dac_register), .pressure_meas_en(pressure_meas_en),
    .temp_current_en(temp_current_en), .readout_comp_en(readout_comp_en),
    .active_mode(active_mode)
  );

  tsw_mcu_model i_mcu (
    .sys_clk(sys_clk), .serial_in_line(serial_in_line), .serial_clk_line(serial_clk_line)
  );

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Cycle count; a hang ends in the failing verdict
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > TIMEOUT_CYC) begin
      miscompares++;
      close_out();
    end
  end

  // Oscillator, divider model and pulse checks six cycles after each rise
  always @(posedge sys_clk) begin
    if (rst) begin
      ph <= 0;
      low_freq_osc <= 1'b0;
      mdiv <= 2;
    end else begin
      ph <= (ph + 1) % 8;
      low_freq_osc <= ((ph + 1) % 8) >= 4;
      if (ph == 3) mdiv <= (mdiv + 1) % RDIV;
      if (ph == 1) begin
        check(mcu_reset_pulse_n, mdiv >= 2, "reset pin");
        if (mdiv < 2) begin
          check(wake_output, 1'b0, "wake with reset");
        end else if (wake_chk) begin
          check(wake_output, (mdiv % WDIV) >= 2, "standby wake");
        end
      end
    end
  end

  // Drives the mode pins, then checks decode and that the threshold held
  task automatic set_mode(input logic [1:0] m);
    wake_chk = 1'b0;
    @(posedge sys_clk);
    mode_sel1 <= m[1];
    mode_sel0 <= m[0];
    repeat (8) @(posedge sys_clk);
    check(active_mode, m, "mode decode");
    check(pressure_meas_en, m == 2'b01, "pressure enable");
    check(temp_current_en, m == 2'b10, "temp current");
    check(readout_comp_en, m == 2'b11, "readout enable");
    check(threshold_dac_register, exp_thr, "held threshold");
    wake_chk = (m == 2'b00);
  endtask

  // Sends a byte; take says whether the device should accept it
  task automatic load(input logic [7:0] b, input logic take);
    i_mcu.send_bits(b, 8);
    repeat (8) @(posedge sys_clk);
    if (take) exp_thr = b;
    check(threshold_dac_register, exp_thr, "threshold");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    // Initialise: pulse a mode pin, then eight zero bits
    set_mode(2'b01);
    set_mode(2'b00);
    load(8'h00, 1'b1);
    // Walking one back to back, one weight at a time
    for (int k = 0; k < 8; k++) begin
      load(8'h01 << k, 1'b1);
    end
    load(8'($random(seed)), 1'b1);
    // Partial byte is discarded by a measure mode
    i_mcu.send_bits(8'hE0, 3);
    set_mode(2'b10);
    set_mode(2'b00);
    load(8'($random(seed)), 1'b1);
    // Clocks during pressure measure are ignored
    set_mode(2'b01);
    load(8'h5A, 1'b0);
    set_mode(2'b11);
    load(8'($random(seed)), 1'b1);
    // Read mode: wake shows the comparator
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      comparator_above <= 1'($random(seed));
      repeat (6) @(posedge sys_clk);
      if (mdiv >= 3) check(wake_output, comparator_above, "comparator");
    end
    // Successive approximation of a modelled sample in read mode
    sample = 8'($random(seed));
    sar = 8'h00;
    for (int k = 7; k >= 0; k--) begin
      load(sar | (8'h01 << k), 1'b1);
      comparator_above <= (sample >= (sar | (8'h01 << k)));
      repeat (6) @(posedge sys_clk);
      while (mdiv < 3) @(posedge sys_clk);
      if (wake_output === 1'b1) sar = sar | (8'h01 << k);
    end
    check(sar, sample, "conversion result");
    set_mode(2'b00);
    while (cyc < 1400) @(posedge sys_clk);
    close_out();
  end
endmodule
`default_nettype wire
